// ==== rtl/mps_pkg.sv ====
// constants and helpers shared by the mii port switch
package mps_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] MPS_CFG_OFS = 8'h00;
  localparam logic [7:0] MPS_STAT_OFS = 8'h04;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int MPS_CLK_SEL_LSB = 0;
  localparam int MPS_EXT_SEL_BIT = 2;
  localparam int MPS_MGMT_SEL_BIT = 3;
  localparam logic [1:0] MPS_CLK_SEL_RST = 2'h0;
  localparam logic MPS_EXT_SEL_RST = 1'b0;
  localparam logic MPS_MGMT_SEL_RST = 1'b0;

  // ----------------------------------------
  // clock source codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    MPS_CLK_INT = 2'b00,
    MPS_CLK_EXT = 2'b01,
    MPS_CLK_OFF = 2'b10,
    MPS_CLK_OFF_ALT = 2'b11
  } mps_clk_sel_t;

  // open a port's clock gates only for that port's own code
  function automatic logic mps_gate_open(input logic [1:0] sel, input logic ext);
    mps_gate_open = ext ? (sel == MPS_CLK_EXT) : (sel == MPS_CLK_INT);
  endfunction

endpackage

// ==== rtl/mps_clk_gate.sv ====
// glitch-free clock gate cell running on the source clock it gates
`timescale 1ns/1ps
module mps_clk_gate (
  input logic clk_in,
  input logic rst_n,
  input logic en_req,
  output logic clk_out,
  output logic gate_on
);

  // ----------------------------------------
  // crossings into the link clock
  // ----------------------------------------
  logic rst_s1_r;
  logic rst_s2_r;
  logic req_s1_r;
  logic req_s2_r;
  logic gate_r;

  always_ff @(posedge clk_in) begin
    rst_s1_r <= rst_n;
    rst_s2_r <= rst_s1_r;
  end

  always_ff @(posedge clk_in) begin
    req_s1_r <= en_req;
    req_s2_r <= req_s1_r;
  end

  // ----------------------------------------
  // gate flop
  // ----------------------------------------
  // change only while clock low
  always_ff @(negedge clk_in) begin
    if (!rst_s2_r) begin
      gate_r <= 1'b0;
    end else begin
      gate_r <= req_s2_r;
    end
  end

  // and of clock with a low-phase enable cannot make a runt
  assign clk_out = clk_in & gate_r;
  assign gate_on = gate_r;

  chk_gate_follow: assert property (@(posedge clk_in) disable iff (!rst_s2_r)
    $changed(req_s2_r) |-> gate_r == req_s2_r ##1 gate_r == $past(req_s2_r))
    else $error("gate enable not taken in the low phase");

endmodule

// ==== rtl/mps_mii_mux.sv ====
// plain routing of mii data and control between the two phys
`timescale 1ns/1ps
module mps_mii_mux (
  input logic ext_sel,
  input logic [3:0] mac_txd,
  input logic mac_tx_en,
  output logic [3:0] mac_rxd,
  output logic mac_rx_dv,
  output logic mac_rx_er,
  output logic mac_crs,
  output logic mac_col,
  output logic [3:0] int_txd,
  output logic int_tx_en,
  input logic [3:0] int_rxd,
  input logic int_rx_dv,
  input logic int_rx_er,
  input logic int_crs,
  input logic int_col,
  output logic [3:0] ext_txd,
  output logic ext_tx_en,
  input logic [3:0] ext_rxd,
  input logic ext_rx_dv,
  input logic ext_rx_er,
  input logic ext_crs,
  input logic ext_col
);

  // deselected phy sees an idle transmitter
  assign int_txd = ext_sel ? 4'h0 : mac_txd;
  assign int_tx_en = ext_sel ? 1'b0 : mac_tx_en;
  assign ext_txd = ext_sel ? mac_txd : 4'h0;
  assign ext_tx_en = ext_sel ? mac_tx_en : 1'b0;

  assign mac_rxd = ext_sel ? ext_rxd : int_rxd;
  assign mac_rx_dv = ext_sel ? ext_rx_dv : int_rx_dv;
  assign mac_rx_er = ext_sel ? ext_rx_er : int_rx_er;
  assign mac_crs = ext_sel ? ext_crs : int_crs;
  assign mac_col = ext_sel ? ext_col : int_col;

endmodule

// ==== rtl/mps_mii_port_switch.sv ====
// mii port switch: clock gating, signal routing and management steering
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module mps_mii_port_switch import mps_pkg::*; (
  input logic clk,
  input logic rst_n,
  // register port
  input logic [7:0] addr,
  input logic [31:0] wdata,
  input logic wr,
  input logic rd,
  output logic [31:0] rdata,
  // phy clocks
  input logic int_tx_clk,
  input logic int_rx_clk,
  input logic ext_tx_clk,
  input logic ext_rx_clk,
  output logic mac_tx_clk,
  output logic mac_rx_clk,
  // mac side mii
  input logic [3:0] mac_txd,
  input logic mac_tx_en,
  output logic [3:0] mac_rxd,
  output logic mac_rx_dv,
  output logic mac_rx_er,
  output logic mac_crs,
  output logic mac_col,
  // integrated phy mii
  output logic [3:0] int_txd,
  output logic int_tx_en,
  input logic [3:0] int_rxd,
  input logic int_rx_dv,
  input logic int_rx_er,
  input logic int_crs,
  input logic int_col,
  // external phy mii
  output logic [3:0] ext_txd,
  output logic ext_tx_en,
  input logic [3:0] ext_rxd,
  input logic ext_rx_dv,
  input logic ext_rx_er,
  input logic ext_crs,
  input logic ext_col,
  // management serial port, mac side
  input logic mgmt_mdc,
  input logic mgmt_mdio_o,
  input logic mgmt_mdio_oe,
  output logic mgmt_mdio_i,
  // management serial port, phy sides
  output logic int_mdc,
  output logic int_mdio_o,
  output logic int_mdio_oe,
  input logic int_mdio_i,
  output logic ext_mdc,
  output logic ext_mdio_o,
  output logic ext_mdio_oe,
  input logic ext_mdio_i
);

  // ----------------------------------------
  // hardware_config_register
  // ----------------------------------------
  logic [1:0] clk_sel_r;
  logic ext_sel_r;
  logic mgmt_sel_r;
  logic cfg_wr;
  logic stat_rd;
  logic cfg_rd;

  assign cfg_wr = wr && (addr == MPS_CFG_OFS);
  assign cfg_rd = rd && (addr == MPS_CFG_OFS);
  assign stat_rd = rd && (addr == MPS_STAT_OFS);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_sel_r <= MPS_CLK_SEL_RST;
    end else if (cfg_wr) begin
      clk_sel_r <= wdata[MPS_CLK_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_sel_r <= MPS_EXT_SEL_RST;
    end else if (cfg_wr) begin
      ext_sel_r <= wdata[MPS_EXT_SEL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mgmt_sel_r <= MPS_MGMT_SEL_RST;
    end else if (cfg_wr) begin
      mgmt_sel_r <= wdata[MPS_MGMT_SEL_BIT];
    end
  end

  // ----------------------------------------
  // gate requests
  // ----------------------------------------
  logic int_en_r;
  logic ext_en_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_en_r <= 1'b0;
      ext_en_r <= 1'b0;
    end else begin
      int_en_r <= mps_gate_open(clk_sel_r, 1'b0);
      ext_en_r <= mps_gate_open(clk_sel_r, 1'b1);
    end
  end

  // ----------------------------------------
  // clock gates
  // ----------------------------------------
  // order: int tx, int rx, ext tx, ext rx
  logic [3:0] src_clk;
  logic [3:0] gated_clk;
  logic [3:0] gate_on;
  logic [3:0] gate_req;

  assign src_clk = {ext_rx_clk, ext_tx_clk, int_rx_clk, int_tx_clk};
  assign gate_req = {ext_en_r, ext_en_r, int_en_r, int_en_r};

  // gates are clocked by their own source
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_gate
      mps_clk_gate u_gate (
        .clk_in(src_clk[gi]),
        .rst_n(rst_n),
        .en_req(gate_req[gi]),
        .clk_out(gated_clk[gi]),
        .gate_on(gate_on[gi])
      );
    end
  endgenerate

  // requests never open both ports, but each gate moves on its own clock, so a direct code change can briefly or two clocks
  assign mac_tx_clk = gated_clk[0] | gated_clk[2];
  assign mac_rx_clk = gated_clk[1] | gated_clk[3];

  // ----------------------------------------
  // gate state back into clk
  // ----------------------------------------
  // a stopped source clock freezes its bit; status shows the last state
  logic [3:0] stat_s1_r;
  logic [3:0] stat_s2_r;

  always_ff @(posedge clk) begin
    stat_s1_r <= gate_on;
    stat_s2_r <= stat_s1_r;
  end

  // ----------------------------------------
  // data multiplexer
  // ----------------------------------------
  // plain mux on the port select
  // data, enables, crs and col follow it
  mps_mii_mux u_mux (
    .ext_sel(ext_sel_r),
    .mac_txd(mac_txd),
    .mac_tx_en(mac_tx_en),
    .mac_rxd(mac_rxd),
    .mac_rx_dv(mac_rx_dv),
    .mac_rx_er(mac_rx_er),
    .mac_crs(mac_crs),
    .mac_col(mac_col),
    .int_txd(int_txd),
    .int_tx_en(int_tx_en),
    .int_rxd(int_rxd),
    .int_rx_dv(int_rx_dv),
    .int_rx_er(int_rx_er),
    .int_crs(int_crs),
    .int_col(int_col),
    .ext_txd(ext_txd),
    .ext_tx_en(ext_tx_en),
    .ext_rxd(ext_rxd),
    .ext_rx_dv(ext_rx_dv),
    .ext_rx_er(ext_rx_er),
    .ext_crs(ext_crs),
    .ext_col(ext_col)
  );

  // ----------------------------------------
  // management serial port
  // ----------------------------------------
  logic mdio_int_s1_r;
  logic mdio_int_s2_r;
  logic mdio_ext_s1_r;
  logic mdio_ext_s2_r;

  always_ff @(posedge clk) begin
    mdio_int_s1_r <= int_mdio_i;
    mdio_int_s2_r <= mdio_int_s1_r;
    mdio_ext_s1_r <= ext_mdio_i;
    mdio_ext_s2_r <= mdio_ext_s1_r;
  end

  // steer independently of the mii mux
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_mdc <= 1'b0;
      int_mdio_o <= 1'b0;
      int_mdio_oe <= 1'b0;
      ext_mdc <= 1'b0;
      ext_mdio_o <= 1'b0;
      ext_mdio_oe <= 1'b0;
      mgmt_mdio_i <= 1'b1;
    end else begin
      int_mdc <= !mgmt_sel_r && mgmt_mdc;
      int_mdio_o <= !mgmt_sel_r && mgmt_mdio_o;
      int_mdio_oe <= !mgmt_sel_r && mgmt_mdio_oe;
      ext_mdc <= mgmt_sel_r && mgmt_mdc;
      ext_mdio_o <= mgmt_sel_r && mgmt_mdio_o;
      ext_mdio_oe <= mgmt_sel_r && mgmt_mdio_oe;
      mgmt_mdio_i <= mgmt_sel_r ? mdio_ext_s2_r : mdio_int_s2_r;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 32'h0;
    end else if (cfg_rd) begin
      rdata <= {28'h0, mgmt_sel_r, ext_sel_r, clk_sel_r};
    end else if (stat_rd) begin
      rdata <= {28'h0, stat_s2_r};
    end else begin
      rdata <= 32'h0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence seq_cfg_wr;
    wr && (addr == MPS_CFG_OFS);
  endsequence

  sequence seq_stat_rd;
    rd && (addr == MPS_STAT_OFS);
  endsequence

  chk_gate_excl: assert property (@(posedge clk) disable iff (!rst_n)
    !(int_en_r && ext_en_r))
    else $error("both ports requested at once");

  chk_off_code: assert property (@(posedge clk) disable iff (!rst_n)
    seq_cfg_wr ##0 (wdata[1:0] == MPS_CLK_OFF) |=> ##1 (!int_en_r && !ext_en_r))
    else $error("off code left a port open");

  // a write right behind may move the code again, so the second cycle needs a quiet bus
  chk_code_map: assert property (@(posedge clk) disable iff (!rst_n)
    seq_cfg_wr ##0 (wdata[1:0] == MPS_CLK_EXT) ##1 !wr |=> (ext_en_r && !int_en_r)[*2])
    else $error("external code did not open the external port");

  chk_port_sel: assert property (@(posedge clk) disable iff (!rst_n)
    seq_cfg_wr |=> ext_sel_r == $past(wdata[MPS_EXT_SEL_BIT]))
    else $error("port select not stored");

  chk_tx_route: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_tx_en == (ext_sel_r && mac_tx_en)) && (int_tx_en == (!ext_sel_r && mac_tx_en)))
    else $error("transmit enable routed to wrong phy");

  chk_rx_route: assert property (@(posedge clk) disable iff (!rst_n)
    mac_rxd == (ext_sel_r ? ext_rxd : int_rxd) && mac_col == (ext_sel_r ? ext_col : int_col))
    else $error("receive side routed from wrong phy");

  chk_mgmt_route: assert property (@(posedge clk) disable iff (!rst_n)
    mgmt_sel_r && mgmt_mdc ##1 mgmt_sel_r |-> ext_mdc && !int_mdc)
    else $error("management clock not steered by its select");

  chk_stat_read: assert property (@(posedge clk) disable iff (!rst_n)
    seq_stat_rd |=> rdata == {28'h0, $past(stat_s2_r)})
    else $error("status read does not show gate state");

endmodule

// ==== tb/mps_phy_model.sv ====
// stand-in for one mii phy: free-running clock, counting receive lines
`timescale 1ns/1ps
module mps_phy_model #(
  parameter realtime PH = 13.0,
  parameter logic RESP = 1'b0
) (
  output logic phy_clk,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic col,
  input logic sw_dat,
  input logic sw_oe,
  output logic mdio
);
  logic [3:0] cnt = 4'h0;
  // full 160 ns periods only, never a runt
  initial begin
    phy_clk = 1'b0;
    #(PH);
    forever #80 phy_clk = ~phy_clk;
  end
  always @(posedge phy_clk) cnt <= cnt + 4'h1;
  assign rxd = cnt;
  // lines kept unequal so a swapped route shows
  assign rx_dv = ~cnt[0];
  assign rx_er = cnt[1] ^ cnt[0];
  assign crs = cnt[2];
  assign col = ~cnt[3];
  // phy answers whenever the switch lets go of the line
  assign mdio = sw_oe ? sw_dat : RESP;
endmodule

// ==== tb/mps_mii_port_switch_tb_top.sv ====
// self-checking bench for the mii port switch
`timescale 1ns/1ps
module mps_mii_port_switch_tb_top import mps_pkg::*;;
  logic clk, rst_n, wr, rd, mac_tx_en, mac_tx_clk, mac_rx_clk, int_clk, ext_clk;
  logic mgmt_mdc, mgmt_mdio_o, mgmt_mdio_oe, mgmt_mdio_i;
  logic int_mdc, int_mdio_o, int_mdio_oe, int_mdio_i, ext_mdc, ext_mdio_o, ext_mdio_oe, ext_mdio_i;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] cfg, mac_txd, mac_rxd, int_txd, ext_txd, int_rxd, ext_rxd;
  logic mac_rx_dv, mac_rx_er, mac_crs, mac_col, int_tx_en, ext_tx_en;
  logic int_rx_dv, int_rx_er, int_crs, int_col, ext_rx_dv, ext_rx_er, ext_crs, ext_col;
  int fail_count = 0, check_count = 0, tx_edges = 0, rx_edges = 0, runts = 0;
  realtime t_rise = 0;

  mps_phy_model #(.PH(13.0), .RESP(1'b0)) u_mps_phy_model_int (.phy_clk(int_clk), .rxd(int_rxd),
    .rx_dv(int_rx_dv), .rx_er(int_rx_er), .crs(int_crs), .col(int_col), .sw_dat(int_mdio_o),
    .sw_oe(int_mdio_oe), .mdio(int_mdio_i));
  mps_phy_model #(.PH(47.0), .RESP(1'b1)) u_mps_phy_model_ext (.phy_clk(ext_clk), .rxd(ext_rxd),
    .rx_dv(ext_rx_dv), .rx_er(ext_rx_er), .crs(ext_crs), .col(ext_col), .sw_dat(ext_mdio_o),
    .sw_oe(ext_mdio_oe), .mdio(ext_mdio_i));
  mps_mii_port_switch u_mps_mii_port_switch (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .int_tx_clk(int_clk), .int_rx_clk(int_clk), .ext_tx_clk(ext_clk), .ext_rx_clk(ext_clk),
    .mac_tx_clk, .mac_rx_clk, .mac_txd, .mac_tx_en, .mac_rxd, .mac_rx_dv, .mac_rx_er, .mac_crs,
    .mac_col, .int_txd, .int_tx_en, .int_rxd, .int_rx_dv, .int_rx_er, .int_crs, .int_col, .ext_txd,
    .ext_tx_en, .ext_rxd, .ext_rx_dv, .ext_rx_er, .ext_crs, .ext_col, .mgmt_mdc, .mgmt_mdio_o,
    .mgmt_mdio_oe, .mgmt_mdio_i, .int_mdc, .int_mdio_o, .int_mdio_oe, .int_mdio_i, .ext_mdc,
    .ext_mdio_o, .ext_mdio_oe, .ext_mdio_i);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge mac_tx_clk) begin
    tx_edges++;
    t_rise = $realtime;
  end
  always @(posedge mac_rx_clk) rx_edges++;
  // a shortened high phase means a runt got through
  always @(negedge mac_tx_clk) if ($realtime - t_rise < 79.0) runts++;

  // ----
  // access and compare tasks
  // ----
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  task automatic poll_stat(input logic [31:0] exp);
    logic [31:0] v;
    int n;
    for (n = 0; n < 60; n++) begin
      rd_reg(MPS_STAT_OFS, v);
      if (v === exp) break;
    end
    chk("status", exp, v);
    if (n == 60) end_of_test();
  endtask
  task automatic chk_route(input logic ext);
    chk("rx", ext ? {ext_rxd, ext_rx_dv, ext_rx_er, ext_crs, ext_col} :
      {int_rxd, int_rx_dv, int_rx_er, int_crs, int_col}, {mac_rxd, mac_rx_dv, mac_rx_er, mac_crs, mac_col});
    chk("tx", ext ? {5'h0, mac_txd, mac_tx_en} : {mac_txd, mac_tx_en, 5'h0},
      {int_txd, int_tx_en, ext_txd, ext_tx_en});
  endtask
  // v is mdc, data out, drive enable
  task automatic chk_mgmt(input logic sel, input logic [2:0] v);
    {mgmt_mdc, mgmt_mdio_o, mgmt_mdio_oe} <= v;
    repeat (4) @(posedge clk);
    #1 chk("mgmt", sel ? {3'h0, v} : {v, 3'h0}, {int_mdc, int_mdio_o, int_mdio_oe, ext_mdc, ext_mdio_o, ext_mdio_oe});
    chk("mdio_in", v[0] ? v[1] : sel, mgmt_mdio_i);
  endtask
  task automatic switch_to(input logic ext);
    // management lines idle so both phys settle first
    chk_mgmt(cfg[3], 3'b000);
    // mac kept quiet over the switch
    mac_tx_en <= 1'b0;
    cfg[1:0] = MPS_CLK_OFF;
    wr_reg(MPS_CFG_OFS, {28'h0, cfg});
    // both phys run at 160 ns, so 10 cycles is over six periods
    repeat (10) @(posedge clk);
    poll_stat(32'h0);
    tx_edges = 0;
    rx_edges = 0;
    repeat (20) @(posedge clk);
    chk("clk_off", 0, tx_edges + rx_edges);
    cfg[2] = ext;
    wr_reg(MPS_CFG_OFS, {28'h0, cfg});
    chk_route(ext);
    cfg[1:0] = ext ? 2'b01 : 2'b00;
    wr_reg(MPS_CFG_OFS, {28'h0, cfg});
    repeat (10) @(posedge clk);
    poll_stat(ext ? 32'hc : 32'h3);
    tx_edges = 0;
    rx_edges = 0;
    repeat (10) @(posedge clk);
    chk("clk_on", 1, (tx_edges > 0) && (rx_edges > 0));
    // transmitter back only after the wait
    mac_txd <= ext ? 4'h9 : 4'h6;
    mac_tx_en <= 1'b1;
    @(posedge clk);
    chk_route(ext);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    {rst_n, wr, rd, mac_tx_en, mgmt_mdc, mgmt_mdio_o, mgmt_mdio_oe} = 7'h0;
    addr = 8'h00;
    wdata = 32'h0;
    mac_txd = 4'h3;
    cfg = 4'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_reg(MPS_CFG_OFS, d);
    chk("cfg_rst", 0, d);
    poll_stat(32'h3);
    chk_route(1'b0);
    wr_reg(MPS_CFG_OFS, 32'hffff_fff0);
    rd_reg(MPS_CFG_OFS, d);
    chk("cfg_hi", 0, d);
    rd_reg(8'h08, d);
    chk("unmapped", 0, d);
    wr_reg(8'h08, 32'h0000_000f);
    rd_reg(MPS_CFG_OFS, d);
    chk("unmapped_wr", 0, d);
    chk_mgmt(1'b0, 3'b111);
    chk_mgmt(1'b0, 3'b100);
    switch_to(1'b1);
    chk_mgmt(1'b0, 3'b010);
    // management idle while its select moves
    cfg[3] = 1'b1;
    wr_reg(MPS_CFG_OFS, {28'h0, cfg});
    chk_mgmt(1'b1, 3'b011);
    chk_mgmt(1'b1, 3'b100);
    cfg[1:0] = 2'b11;
    wr_reg(MPS_CFG_OFS, {28'h0, cfg});
    poll_stat(32'h0);
    switch_to(1'b0);
    chk("runts", 0, runts);
    end_of_test();
  end
endmodule
